// [verilog/slm_defines.vh]
// constants for the serial load port and status output multiplexer
`ifndef SLM_DEFINES_VH
`define SLM_DEFINES_VH

// ============================================================
// shift register and word layout
`define SLM_SR_WIDTH 22
`define SLM_SR_MSB 21
`define SLM_SR_RESET 22'h000000
`define SLM_SEL_HI_BIT 1
`define SLM_SEL_LO_BIT 0
// status source select bits, held in the reference latches
`define SLM_LD_BIT 20
`define SLM_FO_BIT 21

// ============================================================
// latch indices selected by the two control bits
`define SLM_IDX_IF_REF 2'h0
`define SLM_IDX_RF_REF 2'h1
`define SLM_IDX_IF_PROG 2'h2
`define SLM_IDX_RF_PROG 2'h3

// ============================================================
// status source codes {rf_ld, if_ld, rf_fo, if_fo}
`define SLM_ST_OFF 4'h0
`define SLM_ST_IF_LD 4'h4
`define SLM_ST_RF_LD 4'h8
`define SLM_ST_BOTH_LD 4'hc
`define SLM_ST_IF_REF 4'h1
`define SLM_ST_RF_REF 4'h2
`define SLM_ST_IF_PROG 4'h5
`define SLM_ST_RF_PROG 4'h6
`define SLM_ST_HS_LOCK 4'h3
`define SLM_ST_IF_RST 4'h7
`define SLM_ST_RF_RST 4'hb
`define SLM_ST_BOTH_RST 4'hf

// ============================================================
// word buffer
`define SLM_FIFO_DEPTH 4
`define SLM_FIFO_AW 2

`endif

// [verilog/slm_fifo.v]
// small word buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module slm_fifo #(
    parameter WIDTH = 22,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst,
    input wire clk_en,
    input wire wr_valid,
    output wire wr_ready,
    input wire [WIDTH-1:0] wr_data,
    output wire rd_valid,
    input wire rd_ready,
    output wire [WIDTH-1:0] rd_data
);

// ============================================================
// storage and pointers
reg [WIDTH-1:0] mem_q [0:DEPTH-1];
reg [AW-1:0] wr_ptr_q;
reg [AW-1:0] rd_ptr_q;
reg [AW:0] count_q;
wire do_wr;
wire do_rd;
integer i;

// honest full and empty flags
assign wr_ready = (count_q != DEPTH[AW:0]);
assign rd_valid = (count_q != {(AW+1){1'b0}});
assign do_wr = wr_valid & wr_ready;
assign do_rd = rd_valid & rd_ready;
assign rd_data = mem_q[rd_ptr_q];

// pointer, count and storage update
always @(posedge clk or posedge rst) begin
    if (rst) begin
        wr_ptr_q <= {AW{1'b0}};
        rd_ptr_q <= {AW{1'b0}};
        count_q <= {(AW+1){1'b0}};
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= {WIDTH{1'b0}};
        end
    end else if (clk_en) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= wr_data;
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        if (do_rd) begin
            rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        if (do_wr && !do_rd) begin
            count_q <= count_q + {{AW{1'b0}}, 1'b1};
        end else if (do_rd && !do_wr) begin
            count_q <= count_q - {{AW{1'b0}}, 1'b1};
        end
    end
end

endmodule

`default_nettype wire

// [verilog/slm_serial_load.v]
// serial load port with four word latches and the multiplexed status output
//
// Functional notes
// - each rising serial clock edge shifts the data level into the 22-bit register
// - last two bits shifted are control bits, decoded from the lowest positions
// - load strobe rising queues the word in a four-word buffer; it goes into one of four latches by control bits when apply_ready is high
// - status pin drives counter outputs, reference outputs, lock detect or shift register
// - lock detect selection: status high while locked, with brief low pulses
// - counter reset selection holds reference and programmable counters in reset
`timescale 1ns/1ps
`default_nettype none
`include "slm_defines.vh"

module slm_serial_load (
    input wire clk,
    input wire rst,
    input wire clk_en,
    input wire sclk_pin,
    input wire sdata_pin,
    input wire load_strobe,
    input wire apply_ready,
    input wire rf_lock,
    input wire if_lock,
    input wire rf_ref_div,
    input wire if_ref_div,
    input wire rf_prog_div,
    input wire if_prog_div,
    output wire apply_valid,
    output reg [`SLM_SR_MSB:0] latch_if_ref,
    output reg [`SLM_SR_MSB:0] latch_rf_ref,
    output reg [`SLM_SR_MSB:0] latch_if_prog,
    output reg [`SLM_SR_MSB:0] latch_rf_prog,
    output reg status_out,
    output reg rf_counter_reset,
    output reg if_counter_reset,
    output reg hs_lock_mode,
    output reg load_overflow
);

// ============================================================
// pin synchronisers
// bit 0 serial clock, bit 1 serial data, bit 2 load strobe
reg [2:0] sync1_q;
reg [2:0] sync2_q;
reg [2:0] sync3_q;
reg [2:0] filt_q;
reg [2:0] filt_d;
integer k;

// three flops per pin; only stage two and three are compared
always @(posedge clk or posedge rst) begin
    if (rst) begin
        sync1_q <= 3'h0;
        sync2_q <= 3'h0;
        sync3_q <= 3'h0;
    end else if (clk_en) begin
        sync1_q <= {load_strobe, sdata_pin, sclk_pin};
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end
end

// a change counts once stages two and three agree
always @* begin
    filt_d = filt_q;
    for (k = 0; k < 3; k = k + 1) begin
        if (sync2_q[k] == sync3_q[k]) begin
            filt_d[k] = sync3_q[k];
        end
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        filt_q <= 3'h0;
    end else if (clk_en) begin
        filt_q <= filt_d;
    end
end

// edge detection on the filtered levels
wire sclk_rise;
wire strobe_rise;
assign sclk_rise = filt_d[0] & ~filt_q[0];
assign strobe_rise = filt_d[2] & ~filt_q[2];

// ============================================================
// shift register
reg [`SLM_SR_MSB:0] shift_q;
reg [`SLM_SR_MSB:0] shift_d;

// msb enters first and walks up; control bits end in the low positions
always @* begin
    shift_d = shift_q;
    if (sclk_rise) begin
        shift_d = {shift_q[`SLM_SR_MSB-1:0], filt_d[1]};
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        shift_q <= `SLM_SR_RESET;
    end else if (clk_en) begin
        shift_q <= shift_d;
    end
end

// ============================================================
// word buffer between strobe and latches
wire fifo_wr_ready;
wire [`SLM_SR_MSB:0] fifo_rd_data;
wire apply_fire;

// a finished word is queued on the strobe edge; the host keeps the strobe low while shifting
slm_fifo #(
    .WIDTH(`SLM_SR_WIDTH),
    .DEPTH(`SLM_FIFO_DEPTH),
    .AW(`SLM_FIFO_AW)
) u_fifo (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_valid(strobe_rise),
    .wr_ready(fifo_wr_ready),
    .wr_data(shift_q),
    .rd_valid(apply_valid),
    .rd_ready(apply_ready),
    .rd_data(fifo_rd_data)
);

assign apply_fire = apply_valid & apply_ready;

// flag a word dropped because the buffer was full
always @(posedge clk or posedge rst) begin
    if (rst) begin
        load_overflow <= 1'b0;
    end else if (clk_en) begin
        load_overflow <= strobe_rise & ~fifo_wr_ready;
    end
end

// ============================================================
// word latches
wire [1:0] latch_idx;
assign latch_idx = {fifo_rd_data[`SLM_SEL_HI_BIT], fifo_rd_data[`SLM_SEL_LO_BIT]};

// exactly one latch takes the word, chosen by the control bits
always @(posedge clk or posedge rst) begin
    if (rst) begin
        latch_if_ref <= `SLM_SR_RESET;
        latch_rf_ref <= `SLM_SR_RESET;
        latch_if_prog <= `SLM_SR_RESET;
        latch_rf_prog <= `SLM_SR_RESET;
    end else if (clk_en && apply_fire) begin
        case (latch_idx)
            `SLM_IDX_IF_REF: begin
                latch_if_ref <= fifo_rd_data;
            end
            `SLM_IDX_RF_REF: begin
                latch_rf_ref <= fifo_rd_data;
            end
            `SLM_IDX_IF_PROG: begin
                latch_if_prog <= fifo_rd_data;
            end
            default: begin
                latch_rf_prog <= fifo_rd_data;
            end
        endcase
    end
end

// ============================================================
// status source selection
wire [3:0] st_sel;
reg st_d;
reg rf_rst_d;
reg if_rst_d;
reg hs_d;

// select code gathered from both reference latches
assign st_sel = {latch_rf_ref[`SLM_LD_BIT], latch_if_ref[`SLM_LD_BIT],
                 latch_rf_ref[`SLM_FO_BIT], latch_if_ref[`SLM_FO_BIT]};

// output mux; lock inputs already carry the narrow low pulses
always @* begin
    st_d = 1'b0;
    rf_rst_d = 1'b0;
    if_rst_d = 1'b0;
    hs_d = 1'b0;
    case (st_sel)
        `SLM_ST_OFF: begin
            st_d = 1'b0;
        end
        `SLM_ST_IF_LD: begin
            st_d = if_lock;
        end
        `SLM_ST_RF_LD: begin
            st_d = rf_lock;
        end
        `SLM_ST_BOTH_LD: begin
            st_d = rf_lock & if_lock;
        end
        `SLM_ST_IF_REF: begin
            st_d = if_ref_div;
        end
        `SLM_ST_RF_REF: begin
            st_d = rf_ref_div;
        end
        `SLM_ST_IF_PROG: begin
            st_d = if_prog_div;
        end
        `SLM_ST_RF_PROG: begin
            st_d = rf_prog_div;
        end
        `SLM_ST_HS_LOCK: begin
            hs_d = 1'b1; // pin pulled low hard
            st_d = 1'b0;
        end
        `SLM_ST_IF_RST: begin
            if_rst_d = 1'b1;
        end
        `SLM_ST_RF_RST: begin
            rf_rst_d = 1'b1;
        end
        `SLM_ST_BOTH_RST: begin
            rf_rst_d = 1'b1;
            if_rst_d = 1'b1;
        end
        default: begin
            st_d = shift_q[`SLM_SR_MSB];
        end
    endcase
end

// registered status and counter reset outputs
always @(posedge clk or posedge rst) begin
    if (rst) begin
        status_out <= 1'b0;
        rf_counter_reset <= 1'b0;
        if_counter_reset <= 1'b0;
        hs_lock_mode <= 1'b0;
    end else if (clk_en) begin
        status_out <= st_d;
        rf_counter_reset <= rf_rst_d;
        if_counter_reset <= if_rst_d;
        hs_lock_mode <= hs_d;
    end
end

endmodule

`default_nettype wire

// [verilog/README_unused_guard.v]
`timescale 1ns/1ps

// [test/slm_chk_sva.sv]
// assertions on the serial load port outputs
`timescale 1ns/1ps
`default_nettype none
module slm_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic apply_valid,
    input wire logic apply_ready,
    input wire logic rf_lock,
    input wire logic if_lock,
    input wire logic if_ref_div,
    input wire logic [21:0] latch_if_ref,
    input wire logic [21:0] latch_rf_ref,
    input wire logic [21:0] latch_if_prog,
    input wire logic [21:0] latch_rf_prog,
    input wire logic status_out,
    input wire logic rf_counter_reset,
    input wire logic if_counter_reset,
    input wire logic hs_lock_mode,
    input wire logic load_overflow
);
    // ============================================================
    // status source code held in the reference latches
    wire [3:0] code = {latch_rf_ref[20], latch_if_ref[20], latch_rf_ref[21], latch_if_ref[21]};
    wire [87:0] lat = {latch_if_ref, latch_rf_ref, latch_if_prog, latch_rf_prog};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_status_off: assert property (code == 4'h0 |=> !status_out)
        else $error("status not low while disabled");
    a_if_lock: assert property (code == 4'h4 |=> status_out == $past(if_lock))
        else $error("status does not follow if lock");
    a_both_lock: assert property (code == 4'hc |=> status_out == $past(rf_lock && if_lock))
        else $error("status does not follow both locks");
    a_if_ref_out: assert property (code == 4'h1 |=> status_out == $past(if_ref_div))
        else $error("status does not follow if reference");
    a_both_reset: assert property (code == 4'hf |=> rf_counter_reset && if_counter_reset && !status_out)
        else $error("both counters not held in reset");
    a_if_reset: assert property (code == 4'h7 |=> if_counter_reset && !rf_counter_reset)
        else $error("if counter reset wrong");
    a_hs_lock: assert property (code == 4'h3 |=> hs_lock_mode && !status_out)
        else $error("high speed lock mode wrong");
    a_latch_hold: assert property (!(apply_valid && apply_ready) |=> $stable(lat))
        else $error("latch changed without a load");
    a_ovf_pulse: assert property (load_overflow |=> !load_overflow)
        else $error("overflow pulse too long");
endmodule
bind slm_serial_load slm_chk chk_u (.clk(clk), .rst(rst), .apply_valid(apply_valid), .apply_ready(apply_ready),
    .rf_lock(rf_lock), .if_lock(if_lock), .if_ref_div(if_ref_div), .latch_if_ref(latch_if_ref),
    .latch_rf_ref(latch_rf_ref), .latch_if_prog(latch_if_prog), .latch_rf_prog(latch_rf_prog),
    .status_out(status_out), .rf_counter_reset(rf_counter_reset), .if_counter_reset(if_counter_reset),
    .hs_lock_mode(hs_lock_mode), .load_overflow(load_overflow));
`default_nettype wire

// [test/slm_host_model.sv]
// host controller model driving the three-wire programming link
`timescale 1ns/1ps
`default_nettype none
module slm_host_model (
    input wire logic clk,
    output logic sclk_pin,
    output logic sdata_pin,
    output logic load_strobe
);
    // ============================================================
    // link idles with clock low
    initial begin
        sclk_pin = 0;
        sdata_pin = 0;
        load_strobe = 0;
    end
    // one word, msb first, 200 ns serial clock period
    task automatic send_word(input logic [21:0] w);
        for (int i = 21; i >= 0; i--) begin
            sdata_pin = w[i];
            repeat (4) @(negedge clk);
            sclk_pin = 1;
            repeat (4) @(negedge clk);
            sclk_pin = 0;
        end
        sdata_pin = ~w[0]; // released line shows no stale bit
        load_strobe = 1;
        repeat (8) @(negedge clk);
        load_strobe = 0;
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the serial load port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ============================================================
    // signals and counters
    logic clk = 0, rst = 1, apply_ready = 1, go = 0, ce = 1, av, so, rfr, ifr, ovp, hsl;
    logic [5:0] ins = 0;
    logic [21:0] l0, l1, l2, l3, w, nt;
    logic [21:0] notes [$];
    logic [3:0] c;
    logic [3:0] codes [14] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h1, 4'h2, 4'h5, 4'h6, 4'h3, 4'h7, 4'hb, 4'hf, 4'h9, 4'ha};
    wire sclk, sdat, lstr;
    int errors = 0, n_checks = 0, ovf = 0;
    integer seed = 32'h176b;
    always #12.5 clk = ~clk;
    slm_host_model host_u (.clk(clk), .sclk_pin(sclk), .sdata_pin(sdat), .load_strobe(lstr));
    slm_serial_load dut_u (.clk(clk), .rst(rst), .clk_en(ce), .sclk_pin(sclk), .sdata_pin(sdat),
        .load_strobe(lstr), .apply_ready(apply_ready), .rf_lock(ins[5]), .if_lock(ins[4]),
        .rf_ref_div(ins[3]), .if_ref_div(ins[2]), .rf_prog_div(ins[1]), .if_prog_div(ins[0]),
        .apply_valid(av), .latch_if_ref(l0), .latch_rf_ref(l1), .latch_if_prog(l2), .latch_rf_prog(l3),
        .status_out(so), .rf_counter_reset(rfr), .if_counter_reset(ifr), .hs_lock_mode(hsl),
        .load_overflow(ovp));
    task automatic cmp_word(input string nm, input logic [21:0] e, input logic [21:0] g);
        n_checks++;
        if (g !== e) begin errors++; $display("BAD %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin errors++; $display("BAD %s expected %b seen %b", nm, e, g); end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic load(input logic [21:0] v, input bit noted);
        if (noted) notes.push_back(v);
        host_u.send_word(v);
    endtask
    function automatic logic exp_status(input logic [3:0] k, input logic [5:0] v);
        case (k)
            4'h4: return v[4];
            4'h8: return v[5];
            4'hc: return v[5] & v[4];
            4'h1: return v[2];
            4'h2: return v[3];
            4'h5: return v[0];
            4'h6: return v[1];
            4'h9, 4'ha, 4'hd, 4'he: return k[1]; // shift msb = top bit of last word sent
            default: return 1'b0;
        endcase
    endfunction
    // ============================================================
    // monitor: each applied word is checked against the oldest note
    always @(posedge clk) begin
        if (go) begin
            nt = notes.pop_front();
            case (nt[1:0])
                2'h0: cmp_word("latch_if_ref", nt, l0);
                2'h1: cmp_word("latch_rf_ref", nt, l1);
                2'h2: cmp_word("latch_if_prog", nt, l2);
                default: cmp_word("latch_rf_prog", nt, l3);
            endcase
        end
        go <= av && apply_ready && ce;
        if (ovp === 1'b1) ovf++;
    end
    initial begin
        #1000000;
        errors++;
        print_verdict;
    end
    // ============================================================
    // main sequence: latches, status sources, buffer overflow
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            w[1:0] = i[1:0];
            load(w, 1);
        end
        foreach (codes[k]) begin
            c = codes[k];
            w = $random(seed);
            load({c[0], c[2], w[19:2], 2'h0}, 1);
            load({c[1], c[3], w[19:2], 2'h1}, 1);
            repeat (6) @(negedge clk);
            for (int j = 0; j < 16; j++) begin
                ins = $random(seed);
                @(negedge clk);
                cmp_bit("status_out", exp_status(c, ins), so);
                cmp_bit("rf_counter_reset", c == 4'hb || c == 4'hf, rfr);
                cmp_bit("if_counter_reset", c == 4'h7 || c == 4'hf, ifr);
                cmp_bit("hs_lock_mode", c == 4'h3, hsl);
            end
        end
        apply_ready = 0;
        for (int i = 0; i < 5; i++) load($random(seed), i < 4);
        cmp_bit("apply_valid", 1'b1, av);
        // clock enable low freezes the buffer even with ready high
        ce = 0;
        apply_ready = 1;
        repeat (3) @(negedge clk);
        cmp_bit("apply_valid_frozen", 1'b1, av);
        cmp_bit("words_frozen", 1'b1, notes.size() == 4);
        ce = 1;
        repeat (10) @(negedge clk);
        cmp_bit("load_overflow", 1'b1, ovf == 1);
        cmp_bit("apply_valid", 1'b0, av);
        cmp_bit("words_pending", 1'b1, notes.size() == 0);
        print_verdict;
    end
endmodule
`default_nettype wire
